// ### spx_pkg.sv
package spx_pkg;
  // Address widths
  localparam int SEG_W  = 6;
  localparam int PAGE_W = 8;
  localparam int VA_W   = 16;
  localparam int PA_W   = 22;
  localparam int OFF_W  = 14;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_DPR0  = 8'hF0;
  localparam logic [7:0] IDX_CSR   = 8'hF4;
  localparam logic [7:0] IDX_EXTERNAL_MEMORY_CONFIG_TWO  = 8'hF6;
  localparam logic [7:0] IDX_ISEG  = 8'hF8;
  localparam logic [7:0] IDX_DSEG  = 8'hF9;
  localparam logic [7:0] IDX_GRPE0 = 8'hE0;
  // Field positions in external_memory_config_two
  localparam int REMAP_BIT = 5;
  localparam int ISRCS_BIT = 6;
  // Reset values
  localparam logic [7:0]       EXTERNAL_MEMORY_CONFIG_TWO_RST = 8'h0F;
  localparam logic [SEG_W-1:0] CSR_RST  = 6'h00;
  localparam logic [SEG_W-1:0] SEG_RST  = 6'h00;
  localparam logic [7:0]       DPR_RST  = 8'h00;
  localparam logic [7:0]       PORT_RST = 8'hFF;
  // Vector area byte offsets
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_TRAP  = 8'h02;
  localparam logic [7:0] VEC_TOP   = 8'h04;
  // Vector kinds
  localparam logic [1:0] VK_RESET = 2'h0;
  localparam logic [1:0] VK_TRAP  = 2'h1;
  localparam logic [1:0] VK_TOP   = 2'h2;
  localparam logic [1:0] VK_TABLE = 2'h3;
  // Interrupt context of the fetch logic
  typedef enum logic [1:0] {ST_MAIN, ST_ISR_LEGACY, ST_ISR_FULL} spx_ctx_type;
endpackage : spx_pkg

// ### spx_addr_ext.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module spx_addr_ext
  import spx_pkg::*;
#(
  parameter int NEST_W = 4
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Wishbone slave
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [9:0]        ADR_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic [31:0]       DAT_I,
  output logic      [31:0]       DAT_O,
  output logic                   ACK_O,
  // Core fetch and data requests
  input  wire logic              FETCH_REQ,
  input  wire logic [VA_W-1:0]   FETCH_ADDR,
  input  wire logic              DATA_REQ,
  input  wire logic [VA_W-1:0]   DATA_ADDR,
  input  wire logic              VEC_REQ,
  input  wire logic [1:0]        VEC_KIND,
  input  wire logic              VEC_LOW,
  input  wire logic [7:0]        VEC_INDEX,
  // Core control flow events
  input  wire logic              FAR_LOAD,
  input  wire logic [SEG_W-1:0]  FAR_SEG,
  input  wire logic              INT_ENTRY,
  input  wire logic              INT_RETURN,
  input  wire logic [SEG_W-1:0]  STACK_SEG,
  // DMA channel
  input  wire logic              DMA_REQ,
  input  wire logic [VA_W-1:0]   DMA_ADDR,
  input  wire logic              DMA_SEG_SELECT,
  // Physical memory bus
  output logic                   PHYS_VALID,
  output logic      [PA_W-1:0]   PHYS_ADDR,
  // Interrupt stack frame
  output logic                   FRAME_PUSH_CSR,
  output logic      [SEG_W-1:0]  FRAME_CSR,
  // Port 0-3 data registers
  output logic      [31:0]       PORT_DATA
);

  ////////////////////////////////////////////////////////////////
  // Parameter check; the nest count needs at least one bit
  if (NEST_W < 1 || NEST_W > 8) begin : g_nest_check
    $error("NEST_W out of range");
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  logic [SEG_W-1:0]  code_segment_reg;
  logic [SEG_W-1:0]  interrupt_segment_reg;
  logic [SEG_W-1:0]  dma_segment_reg;
  logic [7:0]        data_page_regs [4];
  logic [7:0]        port_data_reg  [4];
  logic [7:0]        external_memory_config_two;
  spx_ctx_type       ctx_reg;
  logic [NEST_W-1:0] nest_reg;
  logic [31:0]       dat_o_reg;
  logic              ack_reg;
  logic              phys_valid_reg;
  logic [PA_W-1:0]   phys_addr_reg;
  logic              frame_push_reg;
  logic [SEG_W-1:0]  frame_csr_reg;

  wire page_reg_remap          = external_memory_config_two[REMAP_BIT];
  wire isr_code_segment_option = external_memory_config_two[ISRCS_BIT];

  ////////////////////////////////////////////////////////////////
  // Address forming
  function automatic logic [PA_W-1:0] seg_addr(input logic [SEG_W-1:0] seg,
                                               input logic [VA_W-1:0] va);
    seg_addr = {seg, va};
  endfunction : seg_addr

  function automatic logic [7:0] vec_offset(input logic [1:0] kind,
                                            input logic       low,
                                            input logic [7:0] index);
    logic [7:0] base;
    base = VEC_TOP;
    if (kind == VK_RESET) base = VEC_RESET;
    else if (kind == VK_TRAP) base = VEC_TRAP;
    else if (kind == VK_TABLE) base = index;
    vec_offset = base | {7'h00, low};
  endfunction : vec_offset

  // Data paging ignores the interrupt context entirely
  wire [1:0]       dpr_sel   = DATA_ADDR[VA_W-1:OFF_W];
  wire [PA_W-1:0]  data_phys = {data_page_regs[dpr_sel], DATA_ADDR[OFF_W-1:0]};
  // Legacy service routines fetch through the interrupt segment
  wire             fetch_isr = (ctx_reg == ST_ISR_LEGACY);
  wire [SEG_W-1:0] fetch_seg = fetch_isr ? interrupt_segment_reg : code_segment_reg;
  wire [SEG_W-1:0] dma_seg   = DMA_SEG_SELECT ? dma_segment_reg : interrupt_segment_reg;
  // Reset vector is fetched before the interrupt segment is set up
  wire [SEG_W-1:0] vec_seg   = (VEC_KIND == VK_RESET) ? code_segment_reg
                                                      : interrupt_segment_reg;
  wire [VA_W-1:0]  vec_va    = {8'h00, vec_offset(VEC_KIND, VEC_LOW, VEC_INDEX)};

  // One request per cycle; vectors, then DMA, then data, then fetch
  wire             any_req   = VEC_REQ | DMA_REQ | DATA_REQ | FETCH_REQ;
  wire [PA_W-1:0]  phys_next = VEC_REQ  ? seg_addr(vec_seg, vec_va) :
                               DMA_REQ  ? seg_addr(dma_seg, DMA_ADDR) :
                               DATA_REQ ? data_phys :
                                          seg_addr(fetch_seg, FETCH_ADDR);

  ////////////////////////////////////////////////////////////////
  // Register bus decode
  wire [7:0] idx      = ADR_I[9:2];
  // Ack blocks a second take, so one strobe is one access
  wire       bus_req  = CYC_I & STB_I & ~ack_reg;
  wire       bus_wr   = bus_req & WE_I & SEL_I[0];
  wire       hit_lowf = idx >= IDX_DPR0 && idx < IDX_CSR;
  wire       hit_e    = idx >= IDX_GRPE0 && idx < IDX_GRPE0 + 8'h04;
  wire       dpr_hit  = page_reg_remap ? hit_e : hit_lowf;
  wire       port_hit = page_reg_remap ? hit_lowf : hit_e;
  wire [1:0] sub      = idx[1:0];
  wire [7:0] rd_next;
  assign rd_next = dpr_hit               ? data_page_regs[sub] :
                   port_hit              ? port_data_reg[sub] :
                   idx == IDX_CSR        ? {2'b00, code_segment_reg} :
                   idx == IDX_EXTERNAL_MEMORY_CONFIG_TWO       ? external_memory_config_two :
                   idx == IDX_ISEG       ? {2'b00, interrupt_segment_reg} :
                   idx == IDX_DSEG       ? {2'b00, dma_segment_reg} : 8'h00;

  ////////////////////////////////////////////////////////////////
  // Interrupt context
  wire               outer_entry = INT_ENTRY & (ctx_reg == ST_MAIN);
  wire               last_return = INT_RETURN & (ctx_reg != ST_MAIN) &
                                   (nest_reg == NEST_W'(1));
  wire               full_ctx    = (ctx_reg == ST_ISR_FULL) |
                                   (outer_entry & isr_code_segment_option);
  spx_ctx_type       ctx_next;
  logic [NEST_W-1:0] nest_next;

  // Nest count saturates; nesting deeper than it holds is not tracked
  always_comb begin
    ctx_next  = ctx_reg;
    nest_next = nest_reg;
    case (ctx_reg)
      ST_MAIN: begin
        if (INT_ENTRY) begin
          ctx_next  = isr_code_segment_option ? ST_ISR_FULL : ST_ISR_LEGACY;
          nest_next = NEST_W'(1);
        end
      end
      default: begin
        if (INT_ENTRY && !INT_RETURN && nest_reg != '1) nest_next = nest_reg + NEST_W'(1);
        else if (INT_RETURN && !INT_ENTRY) nest_next = nest_reg - NEST_W'(1);
        if (last_return && !INT_ENTRY) ctx_next = ST_MAIN;
      end
    endcase
  end

  // Hardware segment changes win over a bus write in the same cycle
  wire [SEG_W-1:0] csr_next =
    (INT_ENTRY && full_ctx)  ? interrupt_segment_reg :
    (INT_RETURN && ctx_reg == ST_ISR_FULL) ? STACK_SEG :
    FAR_LOAD                 ? FAR_SEG :
    (bus_wr && idx == IDX_CSR) ? DAT_I[SEG_W-1:0] : code_segment_reg;

  ////////////////////////////////////////////////////////////////
  // Sequential logic
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctx_reg  <= ST_MAIN;
      nest_reg <= '0;
    end else begin
      ctx_reg  <= ctx_next;
      nest_reg <= nest_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      code_segment_reg           <= CSR_RST;
      interrupt_segment_reg      <= SEG_RST;
      dma_segment_reg            <= SEG_RST;
      external_memory_config_two <= EXTERNAL_MEMORY_CONFIG_TWO_RST;
    end else begin
      code_segment_reg <= csr_next;
      if (bus_wr && idx == IDX_ISEG) interrupt_segment_reg <= DAT_I[SEG_W-1:0];
      if (bus_wr && idx == IDX_DSEG) dma_segment_reg <= DAT_I[SEG_W-1:0];
      if (bus_wr && idx == IDX_EXTERNAL_MEMORY_CONFIG_TWO) external_memory_config_two <= DAT_I[7:0];
    end
  end

  // Port data lives here so the remap swap is a pure decode change
  generate
    for (genvar i = 0; i < 4; i++) begin : g_page
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          data_page_regs[i] <= DPR_RST;
          port_data_reg[i]  <= PORT_RST;
        end else begin
          if (bus_wr && dpr_hit && sub == 2'(i)) data_page_regs[i] <= DAT_I[7:0];
          if (bus_wr && port_hit && sub == 2'(i)) port_data_reg[i] <= DAT_I[7:0];
        end
      end
      assign PORT_DATA[8*i +: 8] = port_data_reg[i];
    end
  endgenerate

  // Read data is zero outside the ack cycle, so no stale byte lingers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_reg   <= 1'b0;
      dat_o_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req;
      dat_o_reg <= bus_req ? {24'h000000, rd_next} : 32'h0000_0000;
    end
  end

  // Old segment is captured on every entry; the push strobe says when it counts
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      phys_valid_reg <= 1'b0;
      phys_addr_reg  <= '0;
      frame_push_reg <= 1'b0;
      frame_csr_reg  <= CSR_RST;
    end else begin
      phys_valid_reg <= any_req;
      if (any_req) phys_addr_reg <= phys_next;
      frame_push_reg <= INT_ENTRY & full_ctx;
      if (INT_ENTRY) frame_csr_reg <= code_segment_reg;
    end
  end

  assign DAT_O          = dat_o_reg;
  assign ACK_O          = ack_reg;
  assign PHYS_VALID     = phys_valid_reg;
  assign PHYS_ADDR      = phys_addr_reg;
  assign FRAME_PUSH_CSR = frame_push_reg;
  assign FRAME_CSR      = frame_csr_reg;

  ////////////////////////////////////////////////////////////////
  // Checks
  opt_reset_a: assert property (@(posedge CLOCK)
    $fell(RST) |-> !isr_code_segment_option) else $error("option not clear after reset");

  // Fetch, DMA, data and vector translation
  legacy_fetch_a: assert property (@(posedge CLOCK) disable iff (RST)
    FETCH_REQ && !VEC_REQ && !DMA_REQ && !DATA_REQ && ctx_reg == ST_ISR_LEGACY
    |=> PHYS_ADDR[PA_W-1:VA_W] == $past(interrupt_segment_reg)) else $error("legacy fetch segment");

  main_fetch_a: assert property (@(posedge CLOCK) disable iff (RST)
    FETCH_REQ && !VEC_REQ && !DMA_REQ && !DATA_REQ && ctx_reg != ST_ISR_LEGACY
    |=> PHYS_VALID && PHYS_ADDR == {$past(code_segment_reg), $past(FETCH_ADDR)})
    else $error("code segment fetch");

  idle_valid_a: assert property (@(posedge CLOCK) disable iff (RST)
    !VEC_REQ && !DMA_REQ && !DATA_REQ && !FETCH_REQ |=> !PHYS_VALID) else $error("spurious memory cycle");

  dma_seg_a: assert property (@(posedge CLOCK) disable iff (RST)
    DMA_REQ && !VEC_REQ |=> PHYS_VALID &&
    PHYS_ADDR == {($past(DMA_SEG_SELECT) ? $past(dma_segment_reg)
                                         : $past(interrupt_segment_reg)), $past(DMA_ADDR)})
    else $error("DMA segment");

  vec_seg_a: assert property (@(posedge CLOCK) disable iff (RST)
    VEC_REQ && VEC_KIND == VK_TOP |=> PHYS_ADDR ==
    {$past(interrupt_segment_reg), 8'h00, VEC_TOP | {7'h00, $past(VEC_LOW)}})
    else $error("vector address");

  vec_trap_a: assert property (@(posedge CLOCK) disable iff (RST)
    VEC_REQ && VEC_KIND == VK_TRAP |=> PHYS_ADDR ==
    {$past(interrupt_segment_reg), 8'h00, VEC_TRAP | {7'h00, $past(VEC_LOW)}})
    else $error("trap vector address");

  vec_table_a: assert property (@(posedge CLOCK) disable iff (RST)
    VEC_REQ && VEC_KIND == VK_TABLE |=> PHYS_ADDR ==
    {$past(interrupt_segment_reg), 8'h00, $past(VEC_INDEX) | {7'h00, $past(VEC_LOW)}})
    else $error("table vector address");

  vec_reset_a: assert property (@(posedge CLOCK) disable iff (RST)
    VEC_REQ && VEC_KIND == VK_RESET |=> PHYS_ADDR ==
    {$past(code_segment_reg), 8'h00, VEC_RESET | {7'h00, $past(VEC_LOW)}})
    else $error("reset vector address");

  data_page_a: assert property (@(posedge CLOCK) disable iff (RST)
    DATA_REQ && !VEC_REQ && !DMA_REQ |=> PHYS_ADDR ==
    {$past(data_page_regs[DATA_ADDR[15:14]]), $past(DATA_ADDR[13:0])})
    else $error("data page translation");

  // Interrupt frame and code segment
  legacy_push_a: assert property (@(posedge CLOCK) disable iff (RST)
    INT_ENTRY && ctx_reg == ST_MAIN && !isr_code_segment_option
    |=> !FRAME_PUSH_CSR) else $error("legacy entry pushed segment");

  legacy_return_a: assert property (@(posedge CLOCK) disable iff (RST)
    INT_RETURN && ctx_reg == ST_ISR_LEGACY && !INT_ENTRY && !FAR_LOAD && !(bus_wr && idx == IDX_CSR)
    |=> $stable(code_segment_reg))
    else $error("legacy return touched segment");

  full_entry_a: assert property (@(posedge CLOCK) disable iff (RST)
    INT_ENTRY && ctx_reg == ST_MAIN && isr_code_segment_option
    |=> FRAME_PUSH_CSR && FRAME_CSR == $past(code_segment_reg) &&
        code_segment_reg == $past(interrupt_segment_reg)) else $error("full entry frame");

  frame_csr_a: assert property (@(posedge CLOCK) disable iff (RST)
    INT_ENTRY |=> FRAME_CSR == $past(code_segment_reg)) else $error("frame segment value");

  full_return_a: assert property (@(posedge CLOCK) disable iff (RST)
    INT_RETURN && !INT_ENTRY && ctx_reg == ST_ISR_FULL
    |=> code_segment_reg == $past(STACK_SEG)) else $error("segment not restored");

  far_load_a: assert property (@(posedge CLOCK) disable iff (RST)
    FAR_LOAD && !INT_ENTRY && !INT_RETURN |=> code_segment_reg == $past(FAR_SEG))
    else $error("far transfer lost");

  csr_write_a: assert property (@(posedge CLOCK) disable iff (RST)
    bus_wr && idx == IDX_CSR && !INT_ENTRY && !INT_RETURN && !FAR_LOAD
    |=> code_segment_reg == $past(DAT_I[SEG_W-1:0])) else $error("code segment write lost");

  // Register bus
  remap_read_a: assert property (@(posedge CLOCK) disable iff (RST)
    bus_req && !WE_I && page_reg_remap && idx == IDX_GRPE0
    |=> ACK_O && DAT_O[7:0] == $past(data_page_regs[0])) else $error("remap read");

  remap_port_a: assert property (@(posedge CLOCK) disable iff (RST)
    bus_wr && page_reg_remap && idx == IDX_DPR0
    |=> PORT_DATA[7:0] == $past(DAT_I[7:0])) else $error("remapped port write");

  bus_ack_a: assert property (@(posedge CLOCK) disable iff (RST)
    ACK_O |=> !ACK_O) else $error("ack held");

endmodule : spx_addr_ext

// ### spx_core_model.sv
`timescale 1ns/1ps
module spx_core_model
  import spx_pkg::*;
(
  // Clock
  input  wire logic         CLOCK,
  // Core requests and control flow events, and DMA requests
  output logic              FETCH_REQ,
  output logic [VA_W-1:0]   FETCH_ADDR,
  output logic              DATA_REQ,
  output logic [VA_W-1:0]   DATA_ADDR,
  output logic              VEC_REQ,
  output logic [1:0]        VEC_KIND,
  output logic              VEC_LOW,
  output logic [7:0]        VEC_INDEX,
  output logic              FAR_LOAD,
  output logic [SEG_W-1:0]  FAR_SEG,
  output logic              INT_ENTRY,
  output logic              INT_RETURN,
  output logic [SEG_W-1:0]  STACK_SEG,
  output logic              DMA_REQ,
  output logic [VA_W-1:0]   DMA_ADDR,
  output logic              DMA_SEG_SELECT
);
  initial begin
    {FETCH_REQ, DATA_REQ, VEC_REQ, FAR_LOAD, INT_ENTRY, INT_RETURN, DMA_REQ} = '0;
    {FETCH_ADDR, DATA_ADDR, DMA_ADDR, VEC_KIND, VEC_LOW, VEC_INDEX} = '0;
    {FAR_SEG, STACK_SEG, DMA_SEG_SELECT} = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Released address, index and segment buses show inverted values, so stale data cannot pass
  task automatic access(input int k, input logic [VA_W-1:0] a, input logic s);
    @(posedge CLOCK);
    {DMA_REQ, DATA_REQ, FETCH_REQ} <= 3'b001 << k;
    {FETCH_ADDR, DATA_ADDR, DMA_ADDR} <= {3{a}};
    DMA_SEG_SELECT <= s;
    @(posedge CLOCK);
    {DMA_REQ, DATA_REQ, FETCH_REQ} <= 3'b000;
    {FETCH_ADDR, DATA_ADDR, DMA_ADDR} <= {3{~a}};
  endtask : access
  task automatic vec(input logic [1:0] kd, input logic lo, input logic [7:0] ix);
    @(posedge CLOCK);
    VEC_REQ <= 1'b1;
    VEC_KIND <= kd;
    VEC_LOW <= lo;
    VEC_INDEX <= ix;
    @(posedge CLOCK);
    VEC_REQ <= 1'b0;
    VEC_INDEX <= ~ix;
  endtask : vec
  task automatic flow(input int k, input logic [SEG_W-1:0] s);
    @(posedge CLOCK);
    {INT_RETURN, INT_ENTRY, FAR_LOAD} <= 3'b001 << k;
    FAR_SEG <= s;
    STACK_SEG <= s;
    @(posedge CLOCK);
    {INT_RETURN, INT_ENTRY, FAR_LOAD} <= 3'b000;
    FAR_SEG <= ~s;
    STACK_SEG <= ~s;
  endtask : flow
endmodule : spx_core_model

// ### segment_page_address_extension_bench.sv
`timescale 1ns/1ps
module segment_page_address_extension_bench
  import spx_pkg::*;
;
  logic              CLOCK, RST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [9:0]        ADR_I = '0;
  logic [3:0]        SEL_I = 4'hF;
  logic [31:0]       DAT_I = '0, DAT_O, PORT_DATA;
  logic              ACK_O, PHYS_VALID, FRAME_PUSH_CSR;
  logic [PA_W-1:0]   PHYS_ADDR;
  logic [SEG_W-1:0]  FRAME_CSR, FAR_SEG, STACK_SEG;
  logic              FETCH_REQ, DATA_REQ, VEC_REQ, VEC_LOW, FAR_LOAD, INT_ENTRY, INT_RETURN, DMA_REQ, DMA_SEG_SELECT;
  logic [VA_W-1:0]   FETCH_ADDR, DATA_ADDR, DMA_ADDR;
  logic [1:0]        VEC_KIND;
  logic [7:0]        VEC_INDEX, rd;
  int                err_total = 0, n_compared = 0;

  spx_addr_ext #(.NEST_W(4)) uut (.CLOCK, .RST, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
    .FETCH_REQ, .FETCH_ADDR, .DATA_REQ, .DATA_ADDR, .VEC_REQ, .VEC_KIND, .VEC_LOW, .VEC_INDEX, .FAR_LOAD,
    .FAR_SEG, .INT_ENTRY, .INT_RETURN, .STACK_SEG, .DMA_REQ, .DMA_ADDR, .DMA_SEG_SELECT, .PHYS_VALID,
    .PHYS_ADDR, .FRAME_PUSH_CSR, .FRAME_CSR, .PORT_DATA);
  spx_core_model core (.CLOCK, .FETCH_REQ, .FETCH_ADDR, .DATA_REQ, .DATA_ADDR, .VEC_REQ, .VEC_KIND, .VEC_LOW,
    .VEC_INDEX, .FAR_LOAD, .FAR_SEG, .INT_ENTRY, .INT_RETURN, .STACK_SEG, .DMA_REQ, .DMA_ADDR, .DMA_SEG_SELECT);

  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hF);
    @(posedge CLOCK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    SEL_I <= sel;
    ADR_I <= {idx, 2'b00};
    DAT_I <= {24'h000000, d};
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge CLOCK);
    end while (ACK_O !== 1'b1);
    rd = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk("register", {24'h000000, rd}, {24'h000000, exp});
  endtask : rdchk
  task automatic xl(input int k, input logic [VA_W-1:0] a, input logic s, input logic [PA_W-1:0] exp);
    core.access(k, a, s);
    @(negedge CLOCK);
    chk("phys", {PHYS_VALID, PHYS_ADDR}, {1'b1, exp});
  endtask : xl
  task automatic vx(input logic [1:0] kd, input logic lo, input logic [7:0] ix, input logic [PA_W-1:0] exp);
    core.vec(kd, lo, ix);
    @(negedge CLOCK);
    chk("vector", {PHYS_VALID, PHYS_ADDR}, {1'b1, exp});
  endtask : vx
  task automatic ev(input int k, input logic [SEG_W-1:0] s);
    core.flow(k, s);
    @(negedge CLOCK);
  endtask : ev
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    @(negedge CLOCK);
    chk("ports", PORT_DATA, 32'hFFFFFFFF);
    rdchk(IDX_EXTERNAL_MEMORY_CONFIG_TWO, 8'h0F);
    rdchk(IDX_CSR, 8'h00);
    rdchk(IDX_GRPE0, 8'hFF);
    rdchk(8'hFC, 8'h00);
    // Data page values stay clear of 21h
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(IDX_DPR0 + i), 8'(8'h11 * (i + 1)));
    // Code segment drives fetch here, so it moves only by far transfers
    ev(0, 6'h05);
    wb(1'b1, IDX_ISEG, 8'h0A);
    wb(1'b1, IDX_DSEG, 8'h1C);
    wb(1'b1, IDX_ISEG, 8'h3F, 4'hE);
    rdchk(IDX_ISEG, 8'h0A);
    for (int i = 0; i < 4; i++) xl(1, {2'(i), 14'h0123}, 1'b0, {8'(8'h11 * (i + 1)), 14'h0123});
    xl(0, 16'h1234, 1'b0, {6'h05, 16'h1234});
    xl(2, 16'h00A0, 1'b0, {6'h0A, 16'h00A0});
    xl(2, 16'h00A1, 1'b1, {6'h1C, 16'h00A1});
    ev(0, 6'h07);
    xl(0, 16'h0100, 1'b0, {6'h07, 16'h0100});
    // Legacy service routine
    ev(1, 6'h00);
    chk("push", {31'h0, FRAME_PUSH_CSR}, 32'h0);
    xl(0, 16'h0200, 1'b0, {6'h0A, 16'h0200});
    wb(1'b1, IDX_CSR, 8'h0B);
    rdchk(IDX_CSR, 8'h0B);
    xl(0, 16'h0202, 1'b0, {6'h0A, 16'h0202});
    ev(0, 6'h09);
    xl(0, 16'h0204, 1'b0, {6'h0A, 16'h0204});
    xl(1, 16'h8001, 1'b0, {8'h33, 14'h0001});
    vx(VK_TRAP, 1'b0, 8'h00, {6'h0A, 16'h0002});
    vx(VK_TOP, 1'b1, 8'h00, {6'h0A, 16'h0005});
    vx(VK_TABLE, 1'b0, 8'h40, {6'h0A, 16'h0040});
    vx(VK_RESET, 1'b1, 8'h00, {6'h09, 16'h0001});
    ev(2, 6'h3F);
    xl(0, 16'h0300, 1'b0, {6'h09, 16'h0300});
    // Full stack frame mode
    wb(1'b1, IDX_EXTERNAL_MEMORY_CONFIG_TWO, 8'h4F);
    rdchk(IDX_EXTERNAL_MEMORY_CONFIG_TWO, 8'h4F);
    ev(1, 6'h00);
    chk("push", {25'h0, FRAME_PUSH_CSR, FRAME_CSR}, {25'h0, 1'b1, 6'h09});
    xl(0, 16'h0400, 1'b0, {6'h0A, 16'h0400});
    ev(0, 6'h12);
    xl(0, 16'h0404, 1'b0, {6'h12, 16'h0404});
    vx(VK_TRAP, 1'b1, 8'h00, {6'h0A, 16'h0003});
    xl(1, 16'hC002, 1'b0, {8'h44, 14'h0002});
    ev(2, 6'h09);
    xl(0, 16'h0500, 1'b0, {6'h09, 16'h0500});
    // Page register relocation
    wb(1'b1, IDX_EXTERNAL_MEMORY_CONFIG_TWO, 8'h6F);
    wb(1'b1, IDX_DPR0, 8'hA5);
    wb(1'b1, IDX_GRPE0, 8'h55);
    @(negedge CLOCK);
    chk("ports", PORT_DATA, 32'hFFFFFFA5);
    xl(1, 16'h0001, 1'b0, {8'h55, 14'h0001});
    rdchk(IDX_GRPE0, 8'h55);
    // Reset again with both options set
    @(posedge CLOCK);
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    rdchk(IDX_EXTERNAL_MEMORY_CONFIG_TWO, 8'h0F);
    chk("ports", PORT_DATA, 32'hFFFFFFFF);
    print_verdict();
  end
endmodule : segment_page_address_extension_bench
